// File: dv/lcrb_far_end_model.sv
// far-end receiver model answering detect attempts
// assumes the answer is taken during the attempt pulse cycle itself
`timescale 1ns/1ps
module lcrb_far_end_model (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic detect_attempt_in,
  input wire logic rx_ready_in,
  output logic far_end_present_out
);
  logic toggle;
  logic next_toggle;
  // free toggle so a sample taken off the pulse shows up as noise
  always_comb begin
    next_toggle = ~toggle;
  end
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      toggle <= 1'b0;
    end else begin
      toggle <= next_toggle;
    end
  end
  // answer stands while the pulse is high, when the sequencer samples it
  assign far_end_present_out = detect_attempt_in ? rx_ready_in : toggle;
endmodule : lcrb_far_end_model

// File: dv/tb_top.sv
// bench for the lane config register bank
// assumes the far-end model is compiled first; short detect period
`timescale 1ns/1ps
module tb_top;
  import lcrb_pkg::*;
  localparam int ACYC = 20;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic ovr = 1'b0;
  logic rdy = 1'b0;
  logic [1:0] pin = 2'h0;
  logic fe, att, term;
  lcrb_req_t req = '0;
  logic [7:0] rdat;
  lcrb_lane_t lane;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  lcrb_lane_cfg #(.ATTEMPT_CYC(ACYC), .MAX_ATTEMPTS(3)) u_dut (.ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in), .req_in(req), .reg_override_in(ovr), .detect_mode_pin_in(pin),
    .far_end_present_in(fe), .rd_data_out(rdat), .lane_out(lane),
    .detect_attempt_out(att), .term_50_out(term));
  lcrb_far_end_model u_far (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .detect_attempt_in(att), .rx_ready_in(rdy), .far_end_present_out(fe));
  initial forever #10 ref_clk_in = ~ref_clk_in;
  // hang guard, far above the planned run length
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{1'b1, 1'b0, a, d};
    tick(1);
    req = '0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    req = '{1'b0, 1'b1, a, 8'h00};
    tick(1);
    req = '0;
    tick(1);
    chk(rdat, e);
  endtask : rd
  // count attempt pulses over n cycles
  task automatic cnt(input int n, output int p);
    p = 0;
    repeat (n) begin
      tick(1);
      if (att === 1'b1) p++;
    end
  endtask : cnt
  // reset values and an unmapped offset
  task automatic t_reset;
    chk(lane, {8'h2F, 1'b1, 3'h5, 3'h2});
    rd(8'h1C, 8'h00);
    rd(8'h1D, 8'h2F);
    rd(8'h1E, 8'hAD);
    rd(8'h1F, 8'h02);
    rd(8'h1B, 8'h00);
  endtask : t_reset
  // readback, every swing code, status immune to writes
  task automatic t_rw;
    wr(8'h1D, 8'hC3);
    rd(8'h1D, 8'hC3);
    wr(8'h1B, 8'hFF);
    rd(8'h1B, 8'h00);
    chk(lane[14:7], 8'hC3);
    // reserved swing bits kept at 0101
    for (int c = 0; c < 8; c++) begin
      wr(8'h1E, 8'h28 | c[7:0]);
      chk(lane, {8'hC3, 1'b0, c[2:0], 3'h2});
    end
    wr(8'h1E, 8'hAE);
    chk(lane, {8'hC3, 1'b1, 3'h6, 3'h2});
    wr(8'h1F, 8'h87);
    rd(8'h1F, 8'h07);
    chk(lane[2:0], 3'h7);
  endtask : t_rw
  // fixed modes by register and by pin
  task automatic t_fixed;
    ovr = 1'b1;
    wr(8'h1C, 8'h0C);
    tick(3);
    chk(term, 1'b1);
    rd(8'h1F, 8'h87);
    ovr = 1'b0;
    tick(4);
    chk(term, 1'b0);
    pin = 2'h3;
    tick(4);
    chk(term, 1'b1);
    pin = 2'h0;
    ovr = 1'b1;
    wr(8'h1C, 8'h00);
    tick(4);
    chk(term, 1'b0);
  endtask : t_fixed
  // limited retries give up, endless ones find the receiver
  task automatic t_auto;
    int p;
    wr(8'h1C, 8'h04);
    cnt(8 * ACYC, p);
    chk(p, 3);
    chk(term, 1'b0);
    wr(8'h1C, 8'h08);
    cnt(5 * ACYC + 8, p);
    chk(p, 5);
    chk(term, 1'b0);
    rdy = 1'b1;
    cnt(ACYC + 4, p);
    chk(p, 1);
    chk(term, 1'b1);
    rd(8'h1F, 8'h87);
  endtask : t_auto
  task automatic end_of_test;
    if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (16) @(posedge ref_clk_in);
    #1;
    rst_n_in = 1'b1;
    t_reset();
    t_rw();
    t_fixed();
    t_auto();
    end_of_test();
  end
endmodule : tb_top

// File: logic/lcrb_lane_cfg.sv
// per-lane config registers with receiver-detect sequencer
// assumes a serial slave front end that hands over decoded byte accesses
`timescale 1ns/1ps
`include "lcrb_consts.svh"

module lcrb_lane_cfg
  import lcrb_pkg::*;
#(
  parameter int ATTEMPT_CYC = `LCRB_ATTEMPT_CYC,
  parameter int MAX_ATTEMPTS = `LCRB_MAX_ATTEMPTS
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire lcrb_req_t req_in,
  input wire logic reg_override_in,
  input wire logic [1:0] detect_mode_pin_in,
  input wire logic far_end_present_in,
  output logic [7:0] rd_data_out,
  output lcrb_lane_t lane_out,
  output logic detect_attempt_out,
  output logic term_50_out
);

  // offsets, reset values and write masks, one entry per register
  localparam int NREG = 4;
  localparam logic [7:0] REG_ADDR [NREG] = '{`LCRB_OFS_DETECT, `LCRB_OFS_EQUALIZER,
    `LCRB_OFS_SWING, `LCRB_OFS_DEEMPH};
  localparam logic [7:0] REG_RST [NREG] = '{`LCRB_RST_DETECT, `LCRB_RST_EQUALIZER,
    `LCRB_RST_SWING, `LCRB_RST_DEEMPH};
  localparam logic [7:0] REG_MASK [NREG] = '{`LCRB_MASK_FULL, `LCRB_MASK_FULL,
    `LCRB_MASK_FULL, `LCRB_MASK_DEEMPH};
  // 20-bit timer holds a full 12 ms period at the 50 MHz clock
  localparam logic [19:0] ATTEMPT_LAST = 20'(ATTEMPT_CYC - 1);
  localparam logic [6:0] ATTEMPT_LIMIT = 7'(MAX_ATTEMPTS);

  // one-hot sequencer states; giveup keeps the input hi-z
  typedef enum logic [4:0] {
    ST_HIZ = 5'h01,
    ST_WAIT = 5'h02,
    ST_CHECK = 5'h04,
    ST_TERM = 5'h08,
    ST_GIVEUP = 5'h10
  } lcrb_state_t;

  logic [7:0] regs [NREG];
  logic [7:0] next_regs [NREG];
  logic [7:0] rd_data;
  logic [7:0] next_rd_data;
  lcrb_lane_t next_lane;
  lcrb_mode_t eff_mode;
  lcrb_mode_t next_eff_mode;
  lcrb_mode_t mode_prev;
  lcrb_state_t state;
  lcrb_state_t next_state;
  logic [19:0] timer;
  logic [19:0] next_timer;
  logic [6:0] attempts;
  logic [6:0] next_attempts;
  logic next_attempt;
  logic next_term;

  // one byte register per entry; the status bit is never stored
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      always_comb begin
        next_regs[gi] = regs[gi];
        if (req_in.wr && req_in.addr == REG_ADDR[gi]) begin
          next_regs[gi] = req_in.data & REG_MASK[gi];
        end
      end
      always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          regs[gi] <= REG_RST[gi];
        end else begin
          regs[gi] <= next_regs[gi];
        end
      end
    end
  endgenerate

  // read mux; unmapped offsets read zero
  always_comb begin
    next_rd_data = rd_data;
    if (req_in.rd) begin
      next_rd_data = 8'h00;
      for (int i = 0; i < NREG; i++) begin
        if (req_in.addr == REG_ADDR[i]) begin
          next_rd_data = regs[i];
        end
      end
      if (req_in.addr == `LCRB_OFS_DEEMPH) begin
        next_rd_data[`LCRB_STAT_BIT] = term_50_out;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  assign rd_data_out = rd_data;

  // lane settings follow the registers one cycle after a write
  always_comb begin
    next_lane.equalizer_setting = next_regs[1];
    next_lane.short_protect = next_regs[2][`LCRB_SCP_BIT];
    next_lane.output_swing = next_regs[2][`LCRB_FIELD3_HI:0];
    next_lane.output_deemphasis = next_regs[3][`LCRB_FIELD3_HI:0];
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lane_out <= '{`LCRB_RST_EQUALIZER, 1'b1, 3'h5, 3'h2};
    end else begin
      lane_out <= next_lane;
    end
  end

  always_comb begin
    if (reg_override_in) begin
      next_eff_mode = lcrb_mode_t'(regs[0][`LCRB_MODE_HI:`LCRB_MODE_LO]);
    end else begin
      next_eff_mode = lcrb_mode_t'(detect_mode_pin_in);
    end
  end

  // detect sequencer; any mode change restarts from hi-z
  always_comb begin
    next_state = state;
    next_timer = timer;
    next_attempts = attempts;
    next_attempt = 1'b0;
    if (eff_mode != mode_prev) begin
      next_state = ST_HIZ;
      next_timer = 20'h00000;
      next_attempts = 7'h00;
    end else begin
      case (state)
        ST_HIZ: begin
          next_timer = 20'h00000;
          next_attempts = 7'h00;
          if (eff_mode == LCRB_MODE_TERM) begin
            next_state = ST_TERM;
          end else if (eff_mode != LCRB_MODE_HIZ) begin
            next_state = ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (timer == ATTEMPT_LAST) begin
            next_timer = 20'h00000;
            next_attempt = 1'b1;
            next_state = ST_CHECK;
          end else begin
            next_timer = timer + 20'h00001;
          end
        end
        ST_CHECK: begin
          next_attempts = attempts + 7'h01;
          if (far_end_present_in) begin
            next_state = ST_TERM;
          end else if (eff_mode == LCRB_MODE_AUTO_LIMITED &&
                       next_attempts >= ATTEMPT_LIMIT) begin
            next_state = ST_GIVEUP; // stays hi-z until mode changes
          end else begin
            next_state = ST_WAIT;
            next_timer = 20'h00001; // check cycle counts toward the period
          end
        end
        ST_TERM: next_state = ST_TERM;
        ST_GIVEUP: next_state = ST_GIVEUP;
        default: next_state = ST_HIZ;
      endcase
    end
    next_term = (next_state == ST_TERM);
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      eff_mode <= LCRB_MODE_HIZ;
      mode_prev <= LCRB_MODE_HIZ;
      state <= ST_HIZ;
      timer <= 20'h00000;
      attempts <= 7'h00;
      detect_attempt_out <= 1'b0;
      term_50_out <= 1'b0;
    end else begin
      eff_mode <= next_eff_mode;
      mode_prev <= eff_mode;
      state <= next_state;
      timer <= next_timer;
      attempts <= next_attempts;
      detect_attempt_out <= next_attempt;
      term_50_out <= next_term;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  mode_term_a: assert property (
    (eff_mode == LCRB_MODE_TERM) [*4] |-> term_50_out)
    else $error("fixed termination mode not terminated");

  mode_hiz_a: assert property (
    (eff_mode == LCRB_MODE_HIZ) [*3] |-> !term_50_out)
    else $error("hi-z mode shows termination");

  attempt_gap_a: assert property (
    detect_attempt_out |=> !detect_attempt_out [*8])
    else $error("detect attempts too close together");

  giveup_count_a: assert property (
    $rose(state == ST_GIVEUP) |->
      attempts == ATTEMPT_LIMIT && eff_mode == LCRB_MODE_AUTO_LIMITED)
    else $error("gave up after wrong attempt count");

  detect_latch_a: assert property (
    $rose(term_50_out) && eff_mode != LCRB_MODE_TERM |->
      $past(state == ST_CHECK) && $past(far_end_present_in))
    else $error("auto termination without detection");

  mode_select_a: assert property (
    ##1 eff_mode == lcrb_mode_t'($past(reg_override_in) ?
      $past(regs[0][`LCRB_MODE_HI:`LCRB_MODE_LO]) : $past(detect_mode_pin_in)))
    else $error("effective mode not from selected source");

  equalizer_write_a: assert property (
    req_in.wr && req_in.addr == `LCRB_OFS_EQUALIZER |=>
      lane_out.equalizer_setting == $past(req_in.data))
    else $error("equalizer write not applied");

  swing_write_a: assert property (
    req_in.wr && req_in.addr == `LCRB_OFS_SWING |=>
      lane_out.output_swing == $past(req_in.data[2:0]) &&
      lane_out.short_protect == $past(req_in.data[7]))
    else $error("swing register write not applied");

  status_read_a: assert property (
    req_in.rd && req_in.addr == `LCRB_OFS_DEEMPH |=>
      rd_data_out[7] == $past(term_50_out) &&
      rd_data_out[6:0] == $past(regs[3][6:0]))
    else $error("status read wrong");

  status_ro_a: assert property (
    req_in.wr && req_in.addr == `LCRB_OFS_DEEMPH |=>
      regs[3][7] == 1'b0 && regs[3][6:0] == $past(req_in.data[6:0]))
    else $error("status bit stored from write");

  // sequencer outcome checks
  attempt_state_a: assert property (
    detect_attempt_out |-> state == ST_CHECK)
    else $error("detect attempt outside check cycle");

  giveup_hiz_a: assert property (
    state == ST_GIVEUP |-> !term_50_out && !detect_attempt_out)
    else $error("given-up lane not idle at hi-z");

  forever_retry_a: assert property (
    state == ST_CHECK && eff_mode == LCRB_MODE_AUTO_FOREVER &&
      eff_mode == mode_prev && !far_end_present_in |=> state == ST_WAIT)
    else $error("endless detect mode stopped retrying");

  term_hold_a: assert property (
    state == ST_TERM && eff_mode == mode_prev |=> term_50_out)
    else $error("termination dropped without mode change");

  detect_ok_c: cover property (state == ST_CHECK && far_end_present_in);
  retry_forever_c: cover property (detect_attempt_out && eff_mode == LCRB_MODE_AUTO_FOREVER);
  giveup_c: cover property ($rose(state == ST_GIVEUP));
  fixed_term_c: cover property ($rose(term_50_out) && eff_mode == LCRB_MODE_TERM);
  equalizer_rw_c: cover property (req_in.wr && req_in.addr == `LCRB_OFS_EQUALIZER ##2 req_in.rd);

endmodule : lcrb_lane_cfg

// File: pkg/lcrb_consts.svh
// constants for the lane configuration register bank
// assumes a 50 MHz device clock and byte-wide register access
`ifndef LCRB_CONSTS_SVH
`define LCRB_CONSTS_SVH
// register offsets
`define LCRB_OFS_DETECT 8'h1C
`define LCRB_OFS_EQUALIZER 8'h1D
`define LCRB_OFS_SWING 8'h1E
`define LCRB_OFS_DEEMPH 8'h1F
// reset values
`define LCRB_RST_DETECT 8'h00
`define LCRB_RST_EQUALIZER 8'h2F
`define LCRB_RST_SWING 8'hAD
`define LCRB_RST_DEEMPH 8'h02
// writable bit masks, status bit excluded
`define LCRB_MASK_FULL 8'hFF
`define LCRB_MASK_DEEMPH 8'h7F
// field positions
`define LCRB_MODE_HI 3
`define LCRB_MODE_LO 2
`define LCRB_SCP_BIT 7
`define LCRB_STAT_BIT 7
`define LCRB_FIELD3_HI 2
// detect timing
`define LCRB_CLK_HZ 50000000
`define LCRB_ATTEMPT_MS 12
`define LCRB_LIMIT_MS 600
`define LCRB_ATTEMPT_CYC ((`LCRB_CLK_HZ / 1000) * `LCRB_ATTEMPT_MS)
`define LCRB_MAX_ATTEMPTS (`LCRB_LIMIT_MS / `LCRB_ATTEMPT_MS)
`endif

// File: pkg/lcrb_pkg.sv
// types for the lane configuration register bank
// assumes the constants header is included alongside
package lcrb_pkg;
  // detect mode codes
  typedef enum logic [1:0] {
    LCRB_MODE_HIZ = 2'h0,
    LCRB_MODE_AUTO_LIMITED = 2'h1,
    LCRB_MODE_AUTO_FOREVER = 2'h2,
    LCRB_MODE_TERM = 2'h3
  } lcrb_mode_t;
  // byte access from the serial slave front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } lcrb_req_t;
  // analog settings handed to the lane
  typedef struct packed {
    logic [7:0] equalizer_setting;
    logic short_protect;
    logic [2:0] output_swing;
    logic [2:0] output_deemphasis;
  } lcrb_lane_t;
endpackage : lcrb_pkg
